/* File: design/exec_map.svh */
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH
`define ACC_RESET        8'h00
`define OPTION_RESET     8'hFF
`define PTR_RESET        16'h0000
`define PTR_STEP         16'h0001
`define MODE_PREINC      2'h0
`define MODE_PREDEC      2'h1
`define MODE_POSTINC     2'h2
`define MODE_POSTDEC     2'h3
`define CARRY_BIT        0
`define DCARRY_BIT       1
`define ZERO_BIT         2
`define STATUS_RESET     3'h0
`define RESET_PULSE_LEN  3'h4
`define NIBBLE_MSB       3
`endif

/* File: design/exec_pkg.sv */
package exec_pkg;
    typedef enum logic [2:0] {
        OP_NOP,
        OP_ADD_CARRY,
        OP_STORE_INDIRECT,
        OP_STORE_RELATIVE,
        OP_LOAD_OPTION,
        OP_SOFT_RESET
    } op_t;

    typedef struct packed {
        logic       valid;
        op_t        op;
        logic [6:0] file_addr;
        logic       dest_file;
        logic       ptr_sel;
        logic [1:0] mode;
        logic [5:0] offset;
    } instr_t;

    typedef struct packed {
        logic        we;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } mem_wr_t;

    typedef enum logic [0:0] {
        RUN,
        RESETTING
    } phase_t;
endpackage

/* File: design/instr_exec.sv */
`timescale 1ns/1ns
`default_nettype none
`include "exec_map.svh"
module instr_exec
    import exec_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire instr_t      instr,
    input  wire logic [7:0]  file_rdata,
    output logic      [7:0]  acc,
    output logic      [2:0]  status,
    output logic      [7:0]  option_cfg,
    output logic      [15:0] ptr0,
    output logic      [15:0] ptr1,
    output logic      [15:0] pc,
    output mem_wr_t          mem_wr,
    output logic             software_reset_flag_n,
    output logic             device_reset
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  acc;
        logic [2:0]  status;
        logic [7:0]  option_cfg;
        logic [15:0] ptr0;
        logic [15:0] ptr1;
        logic [15:0] pc;
        mem_wr_t     mem_wr;
        logic        rflag_n;
        phase_t      phase;
        logic [2:0]  rcount;
        logic        device_reset;
    } state_t;

    state_t      cur;
    state_t      next_cur;
    logic [15:0] sel_ptr;
    logic [15:0] eff_addr;
    logic [15:0] upd_ptr;
    logic [8:0]  sum;
    logic [4:0]  low_sum;

    assign sel_ptr = instr.ptr_sel ? cur.ptr1 : cur.ptr0;

    ptr_update u_ptr (
        .ptr      (sel_ptr),
        .mode     (instr.mode),
        .offset   (instr.offset),
        .relative (instr.op == OP_STORE_RELATIVE),
        .addr     (eff_addr),
        .next_ptr (upd_ptr)
    );

    // ------------------------------------------------------------
    // execute
    // ------------------------------------------------------------
    always_comb
    begin
        next_cur = cur;
        next_cur.mem_wr.we = 1'b0;
        next_cur.device_reset = 1'b0;
        sum = {1'b0, cur.acc} + {1'b0, file_rdata} + {8'h00, cur.status[`CARRY_BIT]};
        low_sum = {1'b0, cur.acc[`NIBBLE_MSB:0]} + {1'b0, file_rdata[`NIBBLE_MSB:0]}
                + {4'h0, cur.status[`CARRY_BIT]};
        unique case (cur.phase)
            RESETTING:
            begin
                // hold reset for a few cycles so every block sees it
                next_cur.device_reset = 1'b1;
                next_cur.rcount = cur.rcount - 3'h1;
                if (cur.rcount == 3'h0)
                begin
                    next_cur = '0;
                    next_cur.acc = `ACC_RESET;
                    next_cur.option_cfg = `OPTION_RESET;
                    next_cur.status = `STATUS_RESET;
                    next_cur.ptr0 = `PTR_RESET;
                    next_cur.ptr1 = `PTR_RESET;
                    next_cur.rflag_n = 1'b0;
                    next_cur.phase = RUN;
                end
            end
            RUN:
            begin
                if (instr.valid)
                begin
                    next_cur.pc = cur.pc + 16'h0001;
                    unique case (instr.op)
                        OP_NOP:
                        begin
                        end
                        OP_ADD_CARRY:
                        begin
                            next_cur.status[`CARRY_BIT]  = sum[8];
                            next_cur.status[`DCARRY_BIT] = low_sum[4];
                            next_cur.status[`ZERO_BIT]   = (sum[7:0] == 8'h00);
                            if (instr.dest_file)
                            begin
                                next_cur.mem_wr.we    = 1'b1;
                                next_cur.mem_wr.addr  = {9'h000, instr.file_addr};
                                next_cur.mem_wr.wdata = sum[7:0];
                            end
                            else
                                next_cur.acc = sum[7:0];
                        end
                        OP_STORE_INDIRECT, OP_STORE_RELATIVE:
                        begin
                            // status untouched here on purpose
                            next_cur.mem_wr.we    = 1'b1;
                            next_cur.mem_wr.addr  = eff_addr;
                            next_cur.mem_wr.wdata = cur.acc;
                            if (instr.ptr_sel)
                                next_cur.ptr1 = upd_ptr;
                            else
                                next_cur.ptr0 = upd_ptr;
                        end
                        OP_LOAD_OPTION:
                            next_cur.option_cfg = cur.acc;
                        OP_SOFT_RESET:
                        begin
                            next_cur.rflag_n = 1'b0;
                            next_cur.phase = RESETTING;
                            next_cur.rcount = `RESET_PULSE_LEN;
                            next_cur.device_reset = 1'b1;
                        end
                        default:
                        begin
                        end
                    endcase
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            cur <= '0;
            cur.acc <= `ACC_RESET;
            cur.option_cfg <= `OPTION_RESET;
            cur.rflag_n <= 1'b1;
            cur.phase <= RUN;
        end
        else
            cur <= next_cur;
    end

    assign acc = cur.acc;
    assign status = cur.status;
    assign option_cfg = cur.option_cfg;
    assign ptr0 = cur.ptr0;
    assign ptr1 = cur.ptr1;
    assign pc = cur.pc;
    assign mem_wr = cur.mem_wr;
    assign software_reset_flag_n = cur.rflag_n;
    assign device_reset = cur.device_reset;
endmodule
`default_nettype wire

/* File: design/ptr_update.sv */
`timescale 1ns/1ns
`default_nettype none
`include "exec_map.svh"
module ptr_update
    import exec_pkg::*;
(
    input  wire logic [15:0] ptr,
    input  wire logic [1:0]  mode,
    input  wire logic [5:0]  offset,
    input  wire logic        relative,
    output logic      [15:0] addr,
    output logic      [15:0] next_ptr
);
    logic [15:0] stepped;

    // 16-bit arithmetic, wrap is natural
    always_comb
    begin
        if (mode[0])
            stepped = ptr - `PTR_STEP;
        else
            stepped = ptr + `PTR_STEP;
        if (relative)
        begin
            addr     = ptr + {{10{offset[5]}}, offset};
            next_ptr = ptr;
        end
        else
        begin
            addr     = mode[1] ? ptr : stepped;
            next_ptr = stepped;
        end
    end
endmodule
`default_nettype wire

/* File: sim/exec_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
// ----
// execution checks
// ----
module exec_chk
    import exec_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire instr_t      instr,
    input wire logic [7:0]  file_rdata,
    input wire logic [7:0]  acc,
    input wire logic [2:0]  status,
    input wire logic [7:0]  option_cfg,
    input wire logic [15:0] ptr0,
    input wire logic [15:0] ptr1,
    input wire logic [15:0] pc,
    input wire mem_wr_t     mem_wr,
    input wire logic        software_reset_flag_n,
    input wire logic        device_reset
);
default clocking @(posedge sys_clk); endclocking
default disable iff (sys_rst);
// refused while a soft reset runs
wire logic        t   = instr.valid && !device_reset;
wire logic [15:0] sp  = instr.ptr_sel ? ptr1 : ptr0;
wire logic [15:0] nx  = instr.mode[0] ? sp - 16'h0001 : sp + 16'h0001;
wire logic [15:0] ea  = instr.mode[1] ? sp : nx;
wire logic [15:0] ra  = sp + {{10{instr.offset[5]}}, instr.offset};
wire logic [8:0]  sum = {1'h0, acc} + {1'h0, file_rdata} + {8'h00, status[0]};
sequence s_reset_run;
    (device_reset && !software_reset_flag_n)[*5] ##1 (!device_reset && pc == 16'h0000 && option_cfg == 8'hFF);
endsequence
property p_add;
    t && instr.op == OP_ADD_CARRY && !instr.dest_file |=> {status[0], acc} == $past(sum) && status[2] == (acc == 8'h00);
endproperty
property p_dest;
    t && instr.op == OP_ADD_CARRY && instr.dest_file |=> mem_wr.we && mem_wr.addr == {9'h000, $past(instr.file_addr)}
        && mem_wr.wdata == $past(sum[7:0]) && $stable(acc);
endproperty
property p_store;
    t && instr.op == OP_STORE_INDIRECT |=> mem_wr.we && mem_wr.wdata == $past(acc) && mem_wr.addr == $past(ea);
endproperty
property p_ptr;
    t && instr.op == OP_STORE_INDIRECT |=> ($past(instr.ptr_sel) ? ptr1 : ptr0) == $past(nx) && $stable(status);
endproperty
property p_rel;
    t && instr.op == OP_STORE_RELATIVE |=> mem_wr.we && mem_wr.addr == $past(ra) && $stable(ptr0) && $stable(ptr1);
endproperty
property p_opt;
    t && instr.op == OP_LOAD_OPTION |=> option_cfg == $past(acc) && $stable(status);
endproperty
property p_soft;
    t && instr.op == OP_SOFT_RESET |=> s_reset_run;
endproperty
property p_nop;
    t && instr.op == OP_NOP |=> pc == $past(pc) + 16'h0001 && $stable(acc) && $stable(status) && $stable(ptr0);
endproperty
a_add: assert property (p_add) else $error("add result wrong");
a_dest: assert property (p_dest) else $error("add to file wrong");
a_store: assert property (p_store) else $error("indirect store wrong");
a_ptr: assert property (p_ptr) else $error("pointer update wrong");
a_rel: assert property (p_rel) else $error("relative store wrong");
a_opt: assert property (p_opt) else $error("option load wrong");
a_soft: assert property (p_soft) else $error("soft reset wrong");
a_nop: assert property (p_nop) else $error("nop changed state");
endmodule
bind instr_exec exec_chk exec_chk_i (.*);
`default_nettype wire

/* File: sim/instr_exec_test.sv */
`timescale 1ns/1ns
`default_nettype none
// ----
// bench
// ----
module instr_exec_test import exec_pkg::*;;
typedef struct packed {
    instr_t i; logic [7:0] d; logic [7:0] a; logic [15:0] p; logic [15:0] m; logic w; logic [2:0] s; logic [7:0] v;
} row_t;
logic sys_clk = 1'h0;
logic sys_rst = 1'h1;
instr_t instr = '0;
logic [7:0] file_rdata = 8'h00;
logic [7:0] acc, option_cfg;
logic [2:0] status;
logic [15:0] ptr0, ptr1, pc;
mem_wr_t mem_wr;
logic software_reset_flag_n, device_reset;
int n_errors = 0;
int total_checks = 0;
row_t rows [14];
function automatic instr_t mk(op_t o, logic x, logic [1:0] md, logic [5:0] f);
    return '{1'h1, o, 7'h7F, x, x, md, f};
endfunction
always #25 sys_clk = ~sys_clk;
instr_exec instr_exec_i (.*);
task chk(logic [15:0] g, logic [15:0] e);
    total_checks++;
    if (g !== e)
    begin
        n_errors++;
        $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
endtask
task complete_run;
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
endtask
// run is some 40 cycles, far below this
initial
begin
    #100000;
    n_errors++;
    complete_run;
end
initial
begin
    rows = '{'{mk(OP_ADD_CARRY,1'h0,2'h0,6'h00),8'hFF,8'hFF,16'h0000,16'h0000,1'h0,3'h0,8'h00},
        '{mk(OP_ADD_CARRY,1'h0,2'h0,6'h00),8'h01,8'h00,16'h0000,16'h0000,1'h0,3'h7,8'h00},
        '{mk(OP_ADD_CARRY,1'h0,2'h0,6'h00),8'h10,8'h11,16'h0000,16'h0000,1'h0,3'h0,8'h00},
        '{mk(OP_STORE_INDIRECT,1'h0,2'h0,6'h00),8'h00,8'h11,16'h0001,16'h0001,1'h1,3'h0,8'h11},
        '{mk(OP_STORE_INDIRECT,1'h0,2'h1,6'h00),8'h00,8'h11,16'h0000,16'h0000,1'h1,3'h0,8'h11},
        '{mk(OP_STORE_INDIRECT,1'h0,2'h1,6'h00),8'h00,8'h11,16'hFFFF,16'hFFFF,1'h1,3'h0,8'h11},
        '{mk(OP_STORE_INDIRECT,1'h0,2'h0,6'h00),8'h00,8'h11,16'h0000,16'h0000,1'h1,3'h0,8'h11},
        '{mk(OP_STORE_INDIRECT,1'h1,2'h2,6'h00),8'h00,8'h11,16'h0001,16'h0000,1'h1,3'h0,8'h11},
        '{mk(OP_STORE_INDIRECT,1'h1,2'h3,6'h00),8'h00,8'h11,16'h0000,16'h0001,1'h1,3'h0,8'h11},
        '{mk(OP_STORE_RELATIVE,1'h0,2'h0,6'h3F),8'h00,8'h11,16'h0000,16'hFFFF,1'h1,3'h0,8'h11},
        '{mk(OP_STORE_RELATIVE,1'h1,2'h0,6'h1F),8'h00,8'h11,16'h0000,16'h001F,1'h1,3'h0,8'h11},
        '{mk(OP_ADD_CARRY,1'h1,2'h0,6'h00),8'h22,8'h11,16'h0000,16'h007F,1'h1,3'h0,8'h33},
        '{mk(OP_LOAD_OPTION,1'h0,2'h0,6'h00),8'h00,8'h11,16'h0000,16'h0000,1'h0,3'h0,8'h00},
        '{mk(OP_NOP,1'h0,2'h0,6'h00),8'h00,8'h11,16'h0000,16'h0000,1'h0,3'h0,8'h00}};
    repeat (16) @(negedge sys_clk);
    sys_rst = 1'h0;
    chk({acc, option_cfg}, 16'h00FF);
    // back to back: row k goes in while row k-1 is checked
    for (int k = 0; k <= 14; k++)
    begin
        if (k > 0)
        begin
            chk(16'(acc), 16'(rows[k-1].a));
            chk(16'(status), 16'(rows[k-1].s));
            chk(rows[k-1].i.ptr_sel ? ptr1 : ptr0, rows[k-1].p);
            chk(16'(mem_wr.we), 16'(rows[k-1].w));
            if (rows[k-1].w) chk(mem_wr.addr, rows[k-1].m);
            if (rows[k-1].w) chk(16'(mem_wr.wdata), 16'(rows[k-1].v));
            chk(pc, 16'(k));
        end
        if (k < 14) {instr, file_rdata} = {rows[k].i, rows[k].d};
        else instr.valid = 1'h0;
        @(negedge sys_clk);
    end
    chk(16'(option_cfg), 16'h0011);
    instr = mk(OP_SOFT_RESET, 1'h0, 2'h0, 6'h00);
    @(negedge sys_clk);
    instr = mk(OP_NOP, 1'h0, 2'h0, 6'h00);
    chk(16'({device_reset, software_reset_flag_n}), 16'h0002);
    repeat (3) @(negedge sys_clk);
    instr.valid = 1'h0;
    for (int j = 0; j < 20 && device_reset !== 1'h0; j++) @(negedge sys_clk);
    chk(pc, 16'h0000);
    chk({acc, option_cfg}, 16'h00FF);
    chk(16'(software_reset_flag_n), 16'h0000);
    sys_rst = 1'h1;
    @(negedge sys_clk);
    sys_rst = 1'h0;
    chk(16'(software_reset_flag_n), 16'h0001);
    complete_run;
end
endmodule
`default_nettype wire
